// ---- rtl/eat_pkg.sv ----
// types shared by the analog trigger detector
package eat_pkg;
  typedef enum logic [3:0] {
    EAT_K_OFF     = 4'h0,
    EAT_K_RISE    = 4'h1,
    EAT_K_FALL    = 4'h2,
    EAT_K_ANY     = 4'h3,
    EAT_K_HIGH    = 4'h4,
    EAT_K_LOW     = 4'h5,
    EAT_K_LONG_P  = 4'h6,
    EAT_K_LONG_N  = 4'h7,
    EAT_K_SHORT_P = 4'h8,
    EAT_K_SHORT_N = 4'h9
  } eat_kind_e;
  typedef enum logic [0:0] {
    EAT_PW_IDLE  = 1'b0,
    EAT_PW_COUNT = 1'b1
  } eat_pw_e;
endpackage : eat_pkg

// ---- rtl/eat_regs.svh ----
// register offsets, field positions, reset values and mode codes
`ifndef EAT_REGS_SVH
`define EAT_REGS_SVH
`define EAT_ADDR_W          16
`define EAT_OFS_OR_MASK     16'h9dda
`define EAT_OFS_AND_MASK    16'h9dee
`define EAT_OFS_MODE        16'h9e3e
`define EAT_OFS_LEVEL       16'ha550
`define EAT_OFS_MAX_PW      16'haca9
`define EAT_OFS_PW_LIMIT    16'hacb2
`define EAT_OFS_IRQ_STATUS  16'hb000
`define EAT_OFS_IRQ_CLEAR   16'hb001
`define EAT_OFS_IRQ_ENABLE  16'hb002
`define EAT_OFS_CONTROL     16'hb003
`define EAT_BIT_MASK_ANALOG 1
`define EAT_BIT_CTRL_ARM    0
`define EAT_BIT_IRQ_TRIG    0
`define EAT_BIT_IRQ_PWEND   1
`define EAT_IRQ_W           2
`define EAT_MODE_NONE       32'h00000000
`define EAT_MODE_POS        32'h00000001
`define EAT_MODE_NEG        32'h00000002
`define EAT_MODE_BOTH       32'h00000004
`define EAT_MODE_HIGH       32'h00000008
`define EAT_MODE_LOW        32'h00000010
`define EAT_MODE_PW_LONG_P  32'h04000001
`define EAT_MODE_PW_LONG_N  32'h04000002
`define EAT_MODE_PW_SHORT_P 32'h02000001
`define EAT_MODE_PW_SHORT_N 32'h02000002
`define EAT_RST_MASK        32'h00000000
`define EAT_RST_MODE        32'h00000000
`define EAT_RST_LEVEL       32'h00000000
`define EAT_RST_PW_LIMIT    32'h00000002
`define EAT_PW_MAX_DEFAULT  32'hffffffff
`endif

// ---- rtl/eat_trigger.sv ----
// main analog input trigger detector with register port and interrupt
//
// Our own choice: the address-and-strobe port.
`timescale 1ns/100ps
`include "eat_regs.svh"

module eat_trigger #(
  parameter int          SAMPLE_W = 16,
  parameter logic [31:0] PW_MAX   = `EAT_PW_MAX_DEFAULT
) (
  // clock and reset
  input  wire logic                   CLK,
  input  wire logic                   RESET_N,
  // converted trigger input, one word per sample in millivolts
  input  wire logic [SAMPLE_W-1:0]    SAMPLE_MV,
  input  wire logic                   SAMPLE_VALID,
  // register port
  input  wire logic [`EAT_ADDR_W-1:0] ADDR,
  input  wire logic [31:0]            WR_DATA,
  input  wire logic                   WR_STB,
  input  wire logic                   RD_STB,
  output logic      [31:0]            RD_DATA,
  // trigger outputs towards the mask logic
  output logic                        TRIG_OR_EVENT,
  output logic                        TRIG_AND_EVENT,
  output logic                        TRIG_GATE,
  // interrupt
  output logic                        IRQ
);

  function automatic eat_pkg::eat_kind_e decode_mode(
    input logic [31:0] m
  );
    eat_pkg::eat_kind_e k;
    k = eat_pkg::EAT_K_OFF;
    if (m == `EAT_MODE_POS)
      k = eat_pkg::EAT_K_RISE;
    else if (m == `EAT_MODE_NEG)
      k = eat_pkg::EAT_K_FALL;
    else if (m == `EAT_MODE_BOTH)
      k = eat_pkg::EAT_K_ANY;
    else if (m == `EAT_MODE_HIGH)
      k = eat_pkg::EAT_K_HIGH;
    else if (m == `EAT_MODE_LOW)
      k = eat_pkg::EAT_K_LOW;
    else if (m == `EAT_MODE_PW_LONG_P)
      k = eat_pkg::EAT_K_LONG_P;
    else if (m == `EAT_MODE_PW_LONG_N)
      k = eat_pkg::EAT_K_LONG_N;
    else if (m == `EAT_MODE_PW_SHORT_P)
      k = eat_pkg::EAT_K_SHORT_P;
    else if (m == `EAT_MODE_PW_SHORT_N)
      k = eat_pkg::EAT_K_SHORT_N;
    return k;
  endfunction : decode_mode

  logic [31:0]               or_mask;
  logic [31:0]               and_mask;
  logic [31:0]               mode;
  logic [31:0]               level;
  logic [31:0]               pw_limit;
  logic [`EAT_IRQ_W-1:0]     irq_status;
  logic [`EAT_IRQ_W-1:0]     irq_enable;
  logic                      arm;
  logic                      armed_check;
  logic                      prev_above;
  logic                      prev_valid;
  logic [31:0]               pw_count;
  eat_pkg::eat_pw_e          pw_state;
  eat_pkg::eat_kind_e        kind;
  logic                      above;
  logic                      below;
  logic                      rise;
  logic                      fall;
  logic                      sole_source;
  logic                      start_x;
  logic                      stop_x;
  logic                      pw_reached;
  logic                      pw_long;
  logic                      next_event;
  logic                      next_gate;
  logic                      pw_end;
  logic [31:0]               next_rd;
  logic [`EAT_IRQ_W-1:0]     irq_set;

  // compare the sample with the programmed millivolt level
  assign kind  = decode_mode(mode);
  assign above = $signed(SAMPLE_MV) > $signed(level[SAMPLE_W-1:0]);
  assign below = $signed(SAMPLE_MV) < $signed(level[SAMPLE_W-1:0]);

  // crossings need two consecutive samples on opposite sides
  assign rise = SAMPLE_VALID & prev_valid & above & ~prev_above;
  assign fall = SAMPLE_VALID & prev_valid & ~above & prev_above;

  // level modes act as an edge only when nothing else is enabled
  assign sole_source = (or_mask == (32'h1 << `EAT_BIT_MASK_ANALOG))
                       && (and_mask == 32'h0);

  assign pw_long = (kind == eat_pkg::EAT_K_LONG_P) ||
                   (kind == eat_pkg::EAT_K_LONG_N);

  always_comb
  begin
    start_x = 1'b0;
    stop_x  = 1'b0;
    case (kind)
      eat_pkg::EAT_K_LONG_P, eat_pkg::EAT_K_SHORT_P:
      begin
        start_x = rise;
        stop_x  = fall;
      end
      eat_pkg::EAT_K_LONG_N, eat_pkg::EAT_K_SHORT_N:
      begin
        start_x = fall;
        stop_x  = rise;
      end
      default:
      begin
        start_x = 1'b0;
        stop_x  = 1'b0;
      end
    endcase
  end

  // 32-bit compare so the whole limit range up to 4G-1 works
  assign pw_reached = (pw_state == eat_pkg::EAT_PW_COUNT) && SAMPLE_VALID
                      && ((pw_count + 32'h1) >= pw_limit);

  always_comb
  begin
    next_event = 1'b0;
    next_gate  = 1'b0;
    pw_end     = 1'b0;
    case (kind)
      eat_pkg::EAT_K_RISE:
        next_event = rise;
      eat_pkg::EAT_K_FALL:
        next_event = fall;
      eat_pkg::EAT_K_ANY:
        next_event = rise | fall;
      eat_pkg::EAT_K_HIGH:
      begin
        next_gate = SAMPLE_VALID ? above : TRIG_GATE;
        if (sole_source)
          next_event = rise | (armed_check & SAMPLE_VALID & above);
        else
          next_event = SAMPLE_VALID & above;
      end
      eat_pkg::EAT_K_LOW:
      begin
        next_gate = SAMPLE_VALID ? below : TRIG_GATE;
        if (sole_source)
          next_event = fall | (armed_check & SAMPLE_VALID & below);
        else
          next_event = SAMPLE_VALID & below;
      end
      eat_pkg::EAT_K_LONG_P, eat_pkg::EAT_K_LONG_N:
      begin
        // the opposite crossing in the same sample wins over the count
        if (pw_state == eat_pkg::EAT_PW_COUNT && stop_x)
          pw_end = 1'b1;
        else if (pw_reached)
          next_event = 1'b1;
      end
      eat_pkg::EAT_K_SHORT_P, eat_pkg::EAT_K_SHORT_N:
      begin
        if (pw_state == eat_pkg::EAT_PW_COUNT && stop_x)
          next_event = 1'b1;
        else if (pw_reached)
          pw_end = 1'b1;
      end
      default:
      begin
        next_event = 1'b0;
        next_gate  = 1'b0;
      end
    endcase
  end

  // sample history for crossing detection
  always_ff @(posedge CLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      prev_above <= 1'b0;
      prev_valid <= 1'b0;
    end
    else if (kind == eat_pkg::EAT_K_OFF || arm)
    begin
      // history restarts so a stale sample cannot fake a crossing
      prev_above <= 1'b0;
      prev_valid <= 1'b0;
    end
    else if (SAMPLE_VALID)
    begin
      prev_above <= above;
      prev_valid <= 1'b1;
    end
  end

  // first sample after arming may fire a level mode at once
  always_ff @(posedge CLK or negedge RESET_N)
  begin
    if (!RESET_N)
      armed_check <= 1'b0;
    else if (arm)
      armed_check <= 1'b1;
    else if (SAMPLE_VALID)
      armed_check <= 1'b0;
  end

  // pulse width counter
  always_ff @(posedge CLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      pw_state <= eat_pkg::EAT_PW_IDLE;
      pw_count <= 32'h0;
    end
    else if (kind == eat_pkg::EAT_K_OFF || arm)
    begin
      pw_state <= eat_pkg::EAT_PW_IDLE;
      pw_count <= 32'h0;
    end
    else
    begin
      case (pw_state)
        eat_pkg::EAT_PW_IDLE:
        begin
          if (start_x)
          begin
            pw_state <= eat_pkg::EAT_PW_COUNT;
            pw_count <= 32'h1;
          end
        end
        eat_pkg::EAT_PW_COUNT:
        begin
          if (start_x)
            pw_count <= 32'h1;
          else if (stop_x || pw_reached)
          begin
            pw_state <= eat_pkg::EAT_PW_IDLE;
            pw_count <= 32'h0;
          end
          else if (SAMPLE_VALID)
            pw_count <= pw_count + 32'h1;
        end
        default:
          pw_state <= eat_pkg::EAT_PW_IDLE;
      endcase
    end
  end

  // trigger outputs, gated by the mask bits
  always_ff @(posedge CLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      TRIG_OR_EVENT  <= 1'b0;
      TRIG_AND_EVENT <= 1'b0;
      TRIG_GATE      <= 1'b0;
    end
    else
    begin
      TRIG_OR_EVENT  <= next_event & or_mask[`EAT_BIT_MASK_ANALOG];
      TRIG_AND_EVENT <= next_event & and_mask[`EAT_BIT_MASK_ANALOG];
      TRIG_GATE      <= next_gate &
                        (or_mask[`EAT_BIT_MASK_ANALOG] |
                         and_mask[`EAT_BIT_MASK_ANALOG]);
    end
  end

  // software writable registers
  always_ff @(posedge CLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      or_mask    <= `EAT_RST_MASK;
      and_mask   <= `EAT_RST_MASK;
      mode       <= `EAT_RST_MODE;
      level      <= `EAT_RST_LEVEL;
      pw_limit   <= `EAT_RST_PW_LIMIT;
      irq_enable <= '0;
    end
    else if (WR_STB)
    begin
      if (ADDR == `EAT_OFS_OR_MASK)
        or_mask <= WR_DATA;
      else if (ADDR == `EAT_OFS_AND_MASK)
        and_mask <= WR_DATA;
      else if (ADDR == `EAT_OFS_MODE)
        mode <= WR_DATA;
      else if (ADDR == `EAT_OFS_LEVEL)
        level <= WR_DATA;
      else if (ADDR == `EAT_OFS_PW_LIMIT)
        pw_limit <= WR_DATA;
      else if (ADDR == `EAT_OFS_IRQ_ENABLE)
        irq_enable <= WR_DATA[`EAT_IRQ_W-1:0];
    end
  end

  // arm pulse restarts detection, like starting the card
  always_ff @(posedge CLK or negedge RESET_N)
  begin
    if (!RESET_N)
      arm <= 1'b0;
    else
      arm <= WR_STB && (ADDR == `EAT_OFS_CONTROL)
             && WR_DATA[`EAT_BIT_CTRL_ARM];
  end

  // sticky status; a new event beats a clear in the same cycle
  assign irq_set = {pw_end, next_event};

  always_ff @(posedge CLK or negedge RESET_N)
  begin
    if (!RESET_N)
      irq_status <= '0;
    else if (WR_STB && ADDR == `EAT_OFS_IRQ_CLEAR)
      irq_status <= (irq_status & ~WR_DATA[`EAT_IRQ_W-1:0]) | irq_set;
    else
      irq_status <= irq_status | irq_set;
  end

  always_ff @(posedge CLK or negedge RESET_N)
  begin
    if (!RESET_N)
      IRQ <= 1'b0;
    else
      IRQ <= |(irq_status & irq_enable);
  end

  // read decode; unmapped and write-only addresses read zero
  always_comb
  begin
    next_rd = 32'h0;
    if (ADDR == `EAT_OFS_OR_MASK)
      next_rd = or_mask;
    else if (ADDR == `EAT_OFS_AND_MASK)
      next_rd = and_mask;
    else if (ADDR == `EAT_OFS_MODE)
      next_rd = mode;
    else if (ADDR == `EAT_OFS_LEVEL)
      next_rd = level;
    else if (ADDR == `EAT_OFS_MAX_PW)
      next_rd = PW_MAX;
    else if (ADDR == `EAT_OFS_PW_LIMIT)
      next_rd = pw_limit;
    else if (ADDR == `EAT_OFS_IRQ_STATUS)
      next_rd = {{(32-`EAT_IRQ_W){1'b0}}, irq_status};
    else if (ADDR == `EAT_OFS_IRQ_ENABLE)
      next_rd = {{(32-`EAT_IRQ_W){1'b0}}, irq_enable};
  end

  // data stands only in the cycle after the strobe
  always_ff @(posedge CLK or negedge RESET_N)
  begin
    if (!RESET_N)
      RD_DATA <= 32'h0;
    else if (RD_STB)
      RD_DATA <= next_rd;
    else
      RD_DATA <= 32'h0;
  end

endmodule : eat_trigger

// ---- verif/eat_src.sv ----
// model of the converted analog trigger signal source
`timescale 1ns/100ps

module eat_src #(
  parameter int SAMPLE_W = 16
) (
  // clock
  input  wire logic                CLK,
  // samples towards the detector
  output logic      [SAMPLE_W-1:0] SAMPLE_MV,
  output logic                     SAMPLE_VALID
);
  initial
  begin
    SAMPLE_MV    = '0;
    SAMPLE_VALID = 1'b0;
  end

  // the word is inverted after its strobe: a held value would hide a
  // detector that reads the input outside the sample strobe
  task automatic put(input logic [SAMPLE_W-1:0] mv);
    @(posedge CLK);
    SAMPLE_MV    <= mv;
    SAMPLE_VALID <= 1'b1;
    @(posedge CLK);
    SAMPLE_MV    <= ~mv;
    SAMPLE_VALID <= 1'b0;
  endtask : put
endmodule : eat_src

// ---- verif/eat_trigger_chk.sv ----
// assertion checker bound to the analog trigger detector
`timescale 1ns/100ps
`include "eat_regs.svh"

module eat_trigger_chk #(
  parameter int          SAMPLE_W = 16,
  parameter logic [31:0] PW_MAX   = `EAT_PW_MAX_DEFAULT
) (
  // clock, reset and samples
  input wire logic                   CLK,
  input wire logic                   RESET_N,
  input wire logic [SAMPLE_W-1:0]    SAMPLE_MV,
  input wire logic                   SAMPLE_VALID,
  // register port
  input wire logic [`EAT_ADDR_W-1:0] ADDR,
  input wire logic [31:0]            WR_DATA,
  input wire logic                   WR_STB,
  input wire logic                   RD_STB,
  input wire logic [31:0]            RD_DATA,
  // trigger outputs and interrupt
  input wire logic                   TRIG_OR_EVENT,
  input wire logic                   TRIG_AND_EVENT,
  input wire logic                   TRIG_GATE,
  input wire logic                   IRQ
);
  logic        or_on;
  logic        and_on;
  logic [31:0] mode;
  logic [31:0] pwl;
  logic [1:0]  en;
  logic        lvl;

  // shadowed from the write strobe, so a register that never updates
  // cannot hide behind its own read-back
  assign lvl = (mode == `EAT_MODE_HIGH) || (mode == `EAT_MODE_LOW);
  always_ff @(posedge CLK or negedge RESET_N)
    if (!RESET_N)
    begin
      or_on  <= 1'b0;
      and_on <= 1'b0;
      mode   <= `EAT_RST_MODE;
      pwl    <= `EAT_RST_PW_LIMIT;
      en     <= 2'h0;
    end
    else if (WR_STB)
    begin
      case (ADDR)
        `EAT_OFS_OR_MASK:    or_on  <= WR_DATA[`EAT_BIT_MASK_ANALOG];
        `EAT_OFS_AND_MASK:   and_on <= WR_DATA[`EAT_BIT_MASK_ANALOG];
        `EAT_OFS_MODE:       mode   <= WR_DATA;
        `EAT_OFS_PW_LIMIT:   pwl    <= WR_DATA;
        `EAT_OFS_IRQ_ENABLE: en     <= WR_DATA[1:0];
        default: ;
      endcase
    end

  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!RESET_N);

  sequence s_rd(logic [15:0] a);
    RD_STB && (ADDR == a);
  endsequence

  property p_rd_idle; !RD_STB |=> RD_DATA == 32'h0; endproperty
  a_rd_idle: assert property (p_rd_idle)
    else $error("read data not zero while idle");
  property p_max; s_rd(`EAT_OFS_MAX_PW) |=> RD_DATA == PW_MAX; endproperty
  a_max: assert property (p_max)
    else $error("wrong maximum pulse count");
  property p_pwl; s_rd(`EAT_OFS_PW_LIMIT) |=> RD_DATA == $past(pwl); endproperty
  a_pwl: assert property (p_pwl)
    else $error("pulse limit read-back differs");
  property p_or; TRIG_OR_EVENT |-> $past(or_on); endproperty
  a_or: assert property (p_or)
    else $error("or event without mask bit");
  property p_and; TRIG_AND_EVENT |-> $past(and_on); endproperty
  a_and: assert property (p_and)
    else $error("and event without mask bit");
  property p_off;
    $past(mode) == `EAT_MODE_NONE |->
      !(TRIG_OR_EVENT || TRIG_AND_EVENT || TRIG_GATE);
  endproperty
  a_off: assert property (p_off)
    else $error("output active in disabled mode");
  property p_gate;
    TRIG_GATE |-> $past(lvl) && ($past(or_on) || $past(and_on));
  endproperty
  a_gate: assert property (p_gate)
    else $error("gate outside level modes");
  // the input word between strobes is not a sample, so the gate holds
  sequence s_no_sample;
    !SAMPLE_VALID && lvl && (or_on || and_on);
  endsequence
  property p_gate_hold; s_no_sample |=> $stable(TRIG_GATE); endproperty
  a_gate_hold: assert property (p_gate_hold)
    else $error("gate moved without a sample");
  property p_valid;
    (TRIG_OR_EVENT || TRIG_AND_EVENT) && !$past(lvl) |-> $past(SAMPLE_VALID);
  endproperty
  a_valid: assert property (p_valid)
    else $error("event without a sample");
  property p_edge;
    TRIG_OR_EVENT && $past(mode) == `EAT_MODE_POS |=> !TRIG_OR_EVENT;
  endproperty
  a_edge: assert property (p_edge)
    else $error("edge event longer than one cycle");
  property p_irq; IRQ |-> $past(en) != 2'h0; endproperty
  a_irq: assert property (p_irq)
    else $error("interrupt with all sources disabled");
endmodule : eat_trigger_chk

bind eat_trigger eat_trigger_chk #(.SAMPLE_W(SAMPLE_W), .PW_MAX(PW_MAX)) u_chk (
  .CLK(CLK), .RESET_N(RESET_N), .SAMPLE_MV(SAMPLE_MV),
  .SAMPLE_VALID(SAMPLE_VALID), .ADDR(ADDR), .WR_DATA(WR_DATA),
  .WR_STB(WR_STB), .RD_STB(RD_STB), .RD_DATA(RD_DATA),
  .TRIG_OR_EVENT(TRIG_OR_EVENT), .TRIG_AND_EVENT(TRIG_AND_EVENT),
  .TRIG_GATE(TRIG_GATE), .IRQ(IRQ));

// ---- verif/testbench.sv ----
// self-checking testbench for the analog trigger detector
`timescale 1ns/100ps
`include "eat_regs.svh"

module testbench;
  typedef struct packed {
    logic [31:0] md;
    logic        o;
    logic        a;
    logic [2:0]  n;
    logic [7:0]  pat;
    logic [7:0]  ev;
    logic [7:0]  g;
  } eat_row_s;

  logic                   CLK = 1'b0;
  logic                   RESET_N = 1'b0;
  logic [`EAT_ADDR_W-1:0] ADDR = '0;
  logic [31:0]            WR_DATA = 32'h0;
  logic                   WR_STB = 1'b0;
  logic                   RD_STB = 1'b0;
  logic [15:0]            SAMPLE_MV;
  logic                   SAMPLE_VALID;
  logic [31:0]            RD_DATA;
  logic                   TRIG_OR_EVENT;
  logic                   TRIG_AND_EVENT;
  logic                   TRIG_GATE;
  logic                   IRQ;
  int                     seed = 6;
  int                     n_fail = 0;
  int                     n_checks = 0;
  logic                   ei = 1'b0;
  logic                   rd_p = 1'b0;
  logic                   sm_p = 1'b0;
  logic [32:0]            rd_q [$];
  logic [2:0]             trg_q [$];
  // pattern bit i is sample i above the level; pulse rows use limit 3
  eat_row_s rows [14] = '{
    '{`EAT_MODE_NONE, 1'b1, 1'b0, 3'd3, 8'h02, 8'h00, 8'h00},
    '{`EAT_MODE_POS, 1'b1, 1'b0, 3'd3, 8'h02, 8'h02, 8'h00},
    '{`EAT_MODE_NEG, 1'b1, 1'b0, 3'd3, 8'h02, 8'h04, 8'h00},
    '{`EAT_MODE_BOTH, 1'b1, 1'b1, 3'd3, 8'h02, 8'h06, 8'h00},
    '{`EAT_MODE_POS, 1'b0, 1'b1, 3'd3, 8'h02, 8'h02, 8'h00},
    '{`EAT_MODE_NEG, 1'b0, 1'b0, 3'd3, 8'h02, 8'h04, 8'h00},
    '{`EAT_MODE_HIGH, 1'b1, 1'b0, 3'd3, 8'h02, 8'h02, 8'h02},
    '{`EAT_MODE_HIGH, 1'b1, 1'b0, 3'd3, 8'h03, 8'h01, 8'h03},
    '{`EAT_MODE_LOW, 1'b1, 1'b0, 3'd3, 8'h02, 8'h05, 8'h05},
    '{`EAT_MODE_HIGH, 1'b1, 1'b1, 3'd4, 8'h06, 8'h06, 8'h06},
    '{`EAT_MODE_PW_LONG_P, 1'b1, 1'b0, 3'd6, 8'h3a, 8'h20, 8'h00},
    '{`EAT_MODE_PW_LONG_N, 1'b1, 1'b0, 3'd6, 8'h05, 8'h20, 8'h00},
    '{`EAT_MODE_PW_SHORT_P, 1'b1, 1'b0, 3'd7, 8'h3a, 8'h04, 8'h00},
    '{`EAT_MODE_PW_SHORT_N, 1'b1, 1'b0, 3'd7, 8'h45, 8'h04, 8'h00}
  };

  always #12.5 CLK = ~CLK;

  eat_src src (.CLK(CLK), .SAMPLE_MV(SAMPLE_MV), .SAMPLE_VALID(SAMPLE_VALID));
  eat_trigger dut (
    .CLK(CLK), .RESET_N(RESET_N), .SAMPLE_MV(SAMPLE_MV),
    .SAMPLE_VALID(SAMPLE_VALID), .ADDR(ADDR), .WR_DATA(WR_DATA),
    .WR_STB(WR_STB), .RD_STB(RD_STB), .RD_DATA(RD_DATA),
    .TRIG_OR_EVENT(TRIG_OR_EVENT), .TRIG_AND_EVENT(TRIG_AND_EVENT),
    .TRIG_GATE(TRIG_GATE), .IRQ(IRQ));

  task automatic wrap_up;
    $display("checks %0d failures %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : wrap_up

  task automatic cmp_rd(input logic [32:0] e, input logic [32:0] g);
    n_checks++;
    if (g !== e)
    begin
      n_fail++;
      $display("CHECK FAILED t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask : cmp_rd

  task automatic cmp_trg(input logic [2:0] e, input logic [2:0] g);
    n_checks++;
    if (g !== e)
    begin
      n_fail++;
      $display("CHECK FAILED t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask : cmp_trg

  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    @(posedge CLK);
    ADDR    <= a;
    WR_DATA <= d;
    WR_STB  <= 1'b1;
    @(posedge CLK);
    WR_STB  <= 1'b0;
  endtask : wr

  task automatic rd(input logic [15:0] a, input logic [31:0] e);
    rd_q.push_back({ei, e});
    @(posedge CLK);
    ADDR   <= a;
    RD_STB <= 1'b1;
    @(posedge CLK);
    RD_STB <= 1'b0;
  endtask : rd

  // random distance from the level, never equal to it
  task automatic sm(input logic h, input logic [2:0] e);
    int r;
    r = $random(seed) & 255;
    trg_q.push_back(e);
    src.put(h ? 16'(101 + r) : 16'(99 - r));
  endtask : sm

  always @(posedge CLK)
  begin
    rd_p <= RD_STB;
    sm_p <= SAMPLE_VALID;
  end

  always @(negedge CLK)
  begin
    if (rd_p)
      cmp_rd(rd_q.pop_front(), {IRQ, RD_DATA});
    if (sm_p)
      cmp_trg(trg_q.pop_front(), {TRIG_OR_EVENT, TRIG_AND_EVENT, TRIG_GATE});
  end

  initial
  begin
    #(25 * 20000);
    n_fail++;
    wrap_up();
  end

  initial
  begin
    logic [31:0] v;
    eat_row_s    w;
    repeat (12) @(posedge CLK);
    RESET_N <= 1'b1;
    rd(`EAT_OFS_OR_MASK, `EAT_RST_MASK);
    rd(`EAT_OFS_AND_MASK, `EAT_RST_MASK);
    rd(`EAT_OFS_MODE, `EAT_MODE_NONE);
    rd(`EAT_OFS_LEVEL, `EAT_RST_LEVEL);
    rd(`EAT_OFS_PW_LIMIT, 32'h2);
    wr(`EAT_OFS_MAX_PW, 32'h5);
    rd(`EAT_OFS_MAX_PW, 32'hffffffff);
    rd(16'h1234, 32'h0);
    for (int i = 0; i < 4; i++)
    begin
      v = (i == 3) ? 32'hffffffff : ($random(seed) | 32'h2);
      wr(`EAT_OFS_PW_LIMIT, v);
      rd(`EAT_OFS_PW_LIMIT, v);
    end
    wr(`EAT_OFS_PW_LIMIT, 32'h3);
    wr(`EAT_OFS_LEVEL, 32'd100);
    foreach (rows[k])
    begin
      w = rows[k];
      wr(`EAT_OFS_MODE, `EAT_MODE_NONE);
      wr(`EAT_OFS_OR_MASK, {30'h0, w.o, 1'b0});
      wr(`EAT_OFS_AND_MASK, {30'h0, w.a, 1'b0});
      wr(`EAT_OFS_CONTROL, 32'h1);
      wr(`EAT_OFS_MODE, w.md);
      for (int i = 0; i < w.n; i++)
        sm(w.pat[i], {w.ev[i] & w.o, w.ev[i] & w.a, w.g[i]});
    end
    // status holds both a trigger and a pulse that ended without one
    rd(`EAT_OFS_IRQ_STATUS, 32'h3);
    wr(`EAT_OFS_IRQ_ENABLE, 32'h2);
    ei = 1'b1;
    rd(`EAT_OFS_IRQ_STATUS, 32'h3);
    wr(`EAT_OFS_IRQ_CLEAR, 32'h2);
    ei = 1'b0;
    rd(`EAT_OFS_IRQ_STATUS, 32'h1);
    wr(`EAT_OFS_IRQ_ENABLE, 32'h1);
    ei = 1'b1;
    rd(`EAT_OFS_IRQ_ENABLE, 32'h1);
    wr(`EAT_OFS_IRQ_CLEAR, 32'h3);
    ei = 1'b0;
    rd(`EAT_OFS_IRQ_STATUS, 32'h0);
    repeat (4) @(posedge CLK);
    wrap_up();
  end
endmodule : testbench
